// file: shared/snvcs_consts.vh
// Purpose: constants for the serial memory command and status front end
// Assumes: msb-first op-codes, eight bits each
// Notes:   definitions only
`ifndef SNVCS_CONSTS_VH
`define SNVCS_CONSTS_VH

`define SNVCS_OP_SET_PERMIT   8'h06
`define SNVCS_OP_CLR_PERMIT   8'h04
`define SNVCS_OP_STATUS_RD    8'h05
`define SNVCS_OP_STATUS_WR    8'h01
`define SNVCS_OP_MEM_RD       8'h03
`define SNVCS_OP_MEM_WR       8'h02
`define SNVCS_OP_IDENT_RD     8'h9f
`define SNVCS_OP_SLEEP        8'hb9

`define SNVCS_BIT_LOCK        7
`define SNVCS_BIT_PERMIT      1
`define SNVCS_BIT_GUARD_HI    3
`define SNVCS_BIT_GUARD_LO    2
`define SNVCS_NV_MASK         8'hfc
`define SNVCS_STATUS_RESET    8'h00
`define SNVCS_CNT_LAST        3'h7
`define SNVCS_CNT_ZERO        3'h0

`endif

// file: hw/snvcs_sync.v
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are levels from outside clk_in's domain
// Notes:   first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module snvcs_sync #(
	parameter W     = 1,
	parameter RST_V = 1'b0
) (
	// clock and reset
	input  wire         clk_in,
	input  wire         rst_in,
	// pins
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] stage1_q;
	reg [W-1:0] stage2_q;

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage1_q <= {W{RST_V}};
			stage2_q <= {W{RST_V}};
		end else begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
		end
	end

	assign sync_out = stage2_q;
endmodule
`default_nettype wire

// file: hw/snvcs_top.v
// Purpose: spi target front end: op-code decode, permit latch, status
// Assumes: serial clock far slower than clk_in; pins sampled by clk_in
// Notes:   array, identity, hold and sleep entry live elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "snvcs_consts.vh"
module snvcs_top (
	// clock and reset
	input  wire       clk_in,
	input  wire       rst_in,
	// spi pins, chip select and guard active low
	input  wire       spi_cs_n_in,
	input  wire       spi_sck_in,
	input  wire       spi_si_in,
	input  wire       write_guard_n_in,
	output wire       spi_so_out,
	output wire       spi_so_oe_out,
	// device side
	input  wire       sleep_return_in,
	output wire       status_write_lock_enable_out,
	output wire       block_guard_sel_hi_out,
	output wire       block_guard_sel_lo_out,
	output wire       write_permit_latch_out,
	output wire       mem_write_allow_out,
	output reg  [7:0] cmd_opcode_out,
	output wire       cmd_valid_out,
	output wire       sleep_req_out
);
	// phases, one-hot
	localparam [4:0] PH_OPCODE = 5'h01;
	localparam [4:0] PH_STRD   = 5'h02;
	localparam [4:0] PH_STWR   = 5'h04;
	localparam [4:0] PH_PASS   = 5'h08;
	localparam [4:0] PH_DONE   = 5'h10;

	wire [3:0] pins_s;
	wire       cs_n_s;
	wire       sck_s;
	wire       si_s;
	wire       guard_n_s;

	// cs and guard idle high so reset looks deselected
	snvcs_sync #(
		.W     (4),
		.RST_V (1'b1)
	) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.async_in ({spi_cs_n_in, spi_sck_in, spi_si_in, write_guard_n_in}),
		.sync_out (pins_s)
	);
	assign cs_n_s    = pins_s[3];
	assign sck_s     = pins_s[2];
	assign si_s      = pins_s[1];
	assign guard_n_s = pins_s[0];

	// edge finder and phase control
	reg       sck_prev_q;
	reg [4:0] phase_q;
	reg [4:0] phase_d;

	// bit counter and input shifter
	reg [2:0] cnt_q;
	reg [6:0] shift_q;

	// status store and permit latch
	reg [7:0] nv_q;
	reg [7:0] nv_d;
	reg       permit_q;
	reg       permit_d;

	// status-read output path
	reg [7:0] tx_q;
	reg [7:0] tx_d;
	reg       so_q;
	reg       so_d;

	// sleep request and command reporting
	reg       sleep_pend_q;
	reg       sleep_pend_d;
	reg       cmd_valid_q;
	reg       sleep_req_q;
	reg [7:0] op_d;
	reg       valid_d;
	reg       sleep_req_d;

	// edges from synchronised clock; mode 0 and 3 both sample rising
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;
	wire active   = ~cs_n_s;
	wire [7:0] byte_in = {shift_q, si_s};
	wire [7:0] status_view;

	// bit 0 forced low, bit 1 is the latch
	assign status_view = {nv_q[7:2], permit_q, 1'b0};

	// blocked if latch clear, or locked while guard low
	// guard pin active low: protected only while lock set and pin low
	wire st_wr_ok = permit_q &
		~(nv_q[`SNVCS_BIT_LOCK] & ~guard_n_s);

	always @* begin
		phase_d      = phase_q;
		permit_d     = permit_q;
		nv_d         = nv_q;
		tx_d         = tx_q;
		so_d         = so_q;
		sleep_pend_d = sleep_pend_q;
		op_d         = cmd_opcode_out;
		valid_d      = 1'b0;
		sleep_req_d  = 1'b0;
		if (sleep_return_in) begin
			permit_d = 1'b0;
		end
		if (!active) begin
			// partial op-code simply dropped on deselect
			phase_d = PH_OPCODE;
			if (sleep_pend_q && phase_q == PH_DONE) begin
				sleep_req_d = 1'b1;
			end
			sleep_pend_d = 1'b0;
		end else begin
			case (phase_q)
			PH_OPCODE: begin
				if (sck_rise && cnt_q == `SNVCS_CNT_LAST) begin
					op_d    = byte_in;
					valid_d = 1'b1;
					case (byte_in)
					`SNVCS_OP_SET_PERMIT: begin
						permit_d = 1'b1;
						phase_d  = PH_DONE;
					end
					`SNVCS_OP_CLR_PERMIT: begin
						permit_d = 1'b0;
						phase_d  = PH_DONE;
					end
					`SNVCS_OP_STATUS_RD: begin
						tx_d    = status_view;
						phase_d = PH_STRD;
					end
					`SNVCS_OP_STATUS_WR: begin
						phase_d = PH_STWR;
					end
					`SNVCS_OP_SLEEP: begin
						sleep_pend_d = 1'b1;
						phase_d      = PH_DONE;
					end
					// memory and identity commands go to the array side
					`SNVCS_OP_MEM_RD,
					`SNVCS_OP_MEM_WR,
					`SNVCS_OP_IDENT_RD: begin
						phase_d = PH_PASS;
					end
					default: begin
						// undefined codes must not arrive; sit it out
						phase_d = PH_DONE;
					end
					endcase
				end
			end
			PH_STRD: begin
				// serial input ignored here
				if (sck_fall) begin
					so_d = tx_q[7];
					tx_d = {tx_q[6:0], 1'b0};
				end
				if (sck_rise && cnt_q == `SNVCS_CNT_LAST) begin
					tx_d = status_view;
				end
			end
			PH_STWR: begin
				if (sck_rise && cnt_q == `SNVCS_CNT_LAST) begin
					if (st_wr_ok) begin
						// latch kept set afterwards
						nv_d = byte_in & `SNVCS_NV_MASK;
					end
					phase_d = PH_DONE;
				end
			end
			PH_PASS: begin
				phase_d = PH_PASS;
			end
			PH_DONE: begin
				// any rising clock edge after sleep op-code cancels it
				if (sck_rise) begin
					sleep_pend_d = 1'b0;
				end
			end
			default: begin
				phase_d = PH_OPCODE;
			end
			endcase
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			// matches synchroniser preset, so no false edge after reset
			sck_prev_q     <= 1'b1;
			phase_q        <= PH_OPCODE;
			cnt_q          <= `SNVCS_CNT_ZERO;
			shift_q        <= 7'h00;
			nv_q           <= `SNVCS_STATUS_RESET;
			permit_q       <= 1'b0;
			tx_q           <= 8'h00;
			so_q           <= 1'b0;
			sleep_pend_q   <= 1'b0;
			cmd_opcode_out <= 8'h00;
			cmd_valid_q    <= 1'b0;
			sleep_req_q    <= 1'b0;
		end else begin
			sck_prev_q     <= sck_s;
			phase_q        <= phase_d;
			nv_q           <= nv_d;
			permit_q       <= permit_d;
			tx_q           <= tx_d;
			so_q           <= so_d;
			sleep_pend_q   <= sleep_pend_d;
			cmd_opcode_out <= op_d;
			cmd_valid_q    <= valid_d;
			sleep_req_q    <= sleep_req_d;
			if (!active) begin
				cnt_q <= `SNVCS_CNT_ZERO;
			end else if (sck_rise) begin
				cnt_q   <= cnt_q + 3'h1;
				shift_q <= byte_in[6:0];
			end
		end
	end

	// released while deselected; only drives in status-read
	assign spi_so_out    = so_q;
	assign spi_so_oe_out = active & (phase_q == PH_STRD);


	// stored status bits straight to the array side
	assign status_write_lock_enable_out = nv_q[`SNVCS_BIT_LOCK];
	assign block_guard_sel_hi_out       = nv_q[`SNVCS_BIT_GUARD_HI];
	assign block_guard_sel_lo_out       = nv_q[`SNVCS_BIT_GUARD_LO];

	// array side applies the guard select bits itself
	assign write_permit_latch_out       = permit_q;
	assign mem_write_allow_out          = permit_q;
	assign cmd_valid_out                = cmd_valid_q;
	assign sleep_req_out                = sleep_req_q;
endmodule
`default_nettype wire

// file: tb/snvcs_asserts.sv
// Purpose: bound checks on the spi front end
// Assumes: one clock domain, pins lag by the synchronisers
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
`include "snvcs_consts.vh"
module snvcs_asserts (
	// clock
	input wire logic       clk_in,
	input wire logic       rst_in,
	// pins
	input wire logic       spi_cs_n_in,
	input wire logic       spi_sck_in,
	input wire logic       write_guard_n_in,
	input wire logic       spi_so_out,
	input wire logic       spi_so_oe_out,
	// status
	input wire logic       status_write_lock_enable_out,
	input wire logic       block_guard_sel_hi_out,
	input wire logic       block_guard_sel_lo_out,
	input wire logic       write_permit_latch_out,
	input wire logic [7:0] cmd_opcode_out,
	input wire logic       cmd_valid_out,
	input wire logic       sleep_req_out
);
	wire logic [2:0] nv = {status_write_lock_enable_out,
		block_guard_sel_hi_out, block_guard_sel_lo_out};
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_OE_IDLE:
	assert property (spi_cs_n_in [*4] |-> !spi_so_oe_out) else $error("oe idle");
	AST_NO_CMD:
	assert property (spi_cs_n_in [*4] |-> !cmd_valid_out) else $error("cmd idle");
	AST_SO_FALL:
	assert property ($changed(spi_so_out) && spi_so_oe_out
		|-> !$past(spi_sck_in, 2)) else $error("so edge");
	AST_VLD_PULSE:
	assert property (cmd_valid_out |=> !cmd_valid_out) else $error("valid");
	AST_SLEEP:
	assert property (sleep_req_out |-> cmd_opcode_out == `SNVCS_OP_SLEEP
		##1 !sleep_req_out) else $error("sleep req");
	AST_SET:
	assert property (cmd_valid_out && cmd_opcode_out == `SNVCS_OP_SET_PERMIT
		|-> ##[0:1] write_permit_latch_out) else $error("set permit");
	AST_NV_HOLD:
	assert property (!write_permit_latch_out |=> $stable(nv)) else $error("nv");
	AST_LOCK:
	assert property ((status_write_lock_enable_out && !write_guard_n_in) [*4]
		|=> $stable(nv)) else $error("locked write");
	cover property (cmd_valid_out && cmd_opcode_out == `SNVCS_OP_STATUS_RD);
	cover property (sleep_req_out);
	cover property ($rose(write_permit_latch_out));
endmodule
bind snvcs_top snvcs_asserts u_snvcs_asserts (.*);
`default_nettype wire

// file: tb/snvcs_host.sv
// Purpose: spi host model for the front end
// Assumes: serial clock 4 clk high, 4 clk low
// Notes:   md picks idle clock level, mode 0 or 3
`timescale 1ns/1ps
`default_nettype none
module snvcs_host (
	// clock
	input  wire logic clk_in,
	// spi pins
	input  wire logic so_in,
	output var logic  cs_n_out,
	output var logic  sck_out,
	output var logic  si_out
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
	end
	task automatic frame(input logic md, input int nb, input logic [23:0] tx,
		output logic [23:0] rx);
		rx = '0;
		@(posedge clk_in) sck_out <= md;
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = 0; i < nb; i++) begin
			sck_out <= 1'b0;
			si_out <= tx[23-i];
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (3) @(posedge clk_in);
			// late in high phase: so is settled well before the next fall
			@(negedge clk_in) rx[23-i] = so_in;
			@(posedge clk_in);
		end
		sck_out <= md;
		si_out <= ~si_out;
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// file: tb/snvcs_top_tb.sv
// Purpose: bench for the spi command and status front end
// Assumes: status flops start at 00
// Notes:   scenarios run in order, each builds on the last
`timescale 1ns/1ps
`default_nettype none
module snvcs_top_tb;
	logic        clk_in = 0, rst_in = 1, guard_n = 1, slp_ret = 0;
	logic [23:0] rx;
	wire  [7:0]  opc;
	wire         cs_n, sck, si, so, oe, lk, bh, bl, write_permit_latch, mwa, vld, slp;
	int          error_cnt = 0, num_checks = 0, cyc = 0, slp_n = 0;
	always #50 clk_in = ~clk_in;
	snvcs_top u_snvcs_top (.clk_in(clk_in), .rst_in(rst_in),
		.spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_si_in(si),
		.write_guard_n_in(guard_n), .spi_so_out(so), .spi_so_oe_out(oe),
		.sleep_return_in(slp_ret), .status_write_lock_enable_out(lk),
		.block_guard_sel_hi_out(bh), .block_guard_sel_lo_out(bl),
		.write_permit_latch_out(write_permit_latch), .mem_write_allow_out(mwa),
		.cmd_opcode_out(opc), .cmd_valid_out(vld), .sleep_req_out(slp));
	snvcs_host u_snvcs_host (.clk_in(clk_in), .so_in(oe ? so : ~so),
		.cs_n_out(cs_n), .sck_out(sck), .si_out(si));
	task check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		slp_n <= slp_n + (slp === 1'b1);
		if (cyc == 10000) begin
			error_cnt++;
			final_report;
		end
	end
	task fr(input logic md, input int nb, input logic [23:0] tx);
		u_snvcs_host.frame(md, nb, tx, rx);
	endtask
	// status byte on the wire, then the same bits at the device side
	task rd(input logic md, input logic [7:0] e);
		fr(md, 16, 24'h050000);
		check(rx[15:8], e);
		check({lk, bh, bl, write_permit_latch, mwa, 3'h0},
			{e[7], e[3:1], e[1], 3'h0});
	endtask
	task t_permit;
		rd(0, 8'h00);
		fr(1, 8, 24'h060000);
		rd(1, 8'h02);
	endtask
	task t_write;
		fr(0, 16, 24'h01ff00);
		rd(0, 8'hfe);
		fr(1, 16, 24'h018c00);
		rd(1, 8'h8e);
		@(posedge clk_in) guard_n <= 1'b0;
		fr(1, 16, 24'h010000);
		rd(0, 8'h8e);
		@(posedge clk_in) guard_n <= 1'b1;
	endtask
	task t_clear;
		fr(0, 8, 24'h040000);
		rd(0, 8'h8c);
		fr(0, 16, 24'h010000);
		rd(1, 8'h8c);
		fr(0, 4, 24'h060000);
		rd(0, 8'h8c);
		fr(1, 24, 24'h05a5a5);
		check(rx[7:0], 8'h8c);
	endtask
	task automatic t_codes;
		logic [7:0] c [4] = '{8'h03, 8'h02, 8'h9f, 8'hb9};
		foreach (c[i]) begin
			fr(i[0], 8, {c[i], 16'h0});
			check(opc, c[i]);
		end
		check(slp_n[7:0], 8'h01);
		fr(0, 8, 24'h060000);
		@(posedge clk_in) slp_ret <= 1'b1;
		@(posedge clk_in) slp_ret <= 1'b0;
		rd(1, 8'h8c);
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		t_permit;
		t_write;
		t_clear;
		t_codes;
		final_report;
	end
endmodule
`default_nettype wire
